// [core/acc_load_pkg.sv]
// Opcodes, field positions and reset values for the accumulator load instructions.
package acc_load_pkg;
  localparam int          INSTR_W        = 10;
  localparam int          NIB_W          = 4;
  localparam logic [9:0]  OPC_WAKE_ONE   = 10'h25B;
  localparam logic [9:0]  OPC_WAKE_TWO   = 10'h25A;
  localparam logic [9:0]  OPC_LCD_ONE    = 10'h24A;
  localparam logic [9:0]  OPC_MEM_LOAD   = 10'h2C0;
  localparam logic [9:0]  OPC_MEM_MASK   = 10'h3F0;
  localparam int          IMM_LSB        = 0;
  localparam logic [3:0]  ACC_RST        = 4'h0;
  localparam logic [3:0]  MEMFILE_RST    = 4'h0;
  localparam int          EXEC_CYCLES    = 1;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_WAKE_ONE,
    OP_WAKE_TWO,
    OP_LCD_ONE,
    OP_MEM_LOAD
  } op_t;
endpackage : acc_load_pkg

// [core/acc_load_instructions.sv]
// Decoder and executor for the single-cycle accumulator load instructions.
//
// Behaviour
// - Wakeup-control-one read opcode copies wakeup control register one into accumulator, one cycle.
// - Wakeup-control-two read copies wakeup control register two into accumulator, one cycle.
// - LCD-control-one read loads accumulator from LCD control register one, one cycle.
// - Memory-load opcode copies the nibble at the data pointer into accumulator, one cycle.
// - Memory-load also XORs memory-file register with its 4-bit immediate, any value 0-15.
`timescale 1ns/1ns
module acc_load_instructions (
  input  wire logic       CORE_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       CE,
  input  wire logic       INSTR_VALID,
  input  wire logic [9:0] INSTR,
  input  wire logic [3:0] WAKEUP_CTRL_ONE,
  input  wire logic [3:0] WAKEUP_CTRL_TWO,
  input  wire logic [3:0] LCD_CTRL_ONE,
  input  wire logic [3:0] MEM_RDATA,
  input  wire logic       ACC_WR,
  input  wire logic [3:0] ACC_WDATA,
  input  wire logic       MEMFILE_WR,
  input  wire logic [3:0] MEMFILE_WDATA,
  output logic      [3:0] ACC,
  output logic      [3:0] MEMFILE,
  output logic            DONE,
  output logic            SKIP_NEXT,
  output logic            CARRY_WE
);

  // ==========================================================================
  // Decode
  // ==========================================================================

  acc_load_pkg::op_t op;
  logic [3:0]        imm;

  // Classifies the current instruction word into one of the handled loads.
  always_comb begin
    op  = acc_load_pkg::OP_NONE;
    imm = INSTR[acc_load_pkg::IMM_LSB +: acc_load_pkg::NIB_W];
    if (INSTR_VALID) begin
      if (INSTR == acc_load_pkg::OPC_WAKE_ONE) begin
        op = acc_load_pkg::OP_WAKE_ONE;
      end else if (INSTR == acc_load_pkg::OPC_WAKE_TWO) begin
        op = acc_load_pkg::OP_WAKE_TWO;
      end else if (INSTR == acc_load_pkg::OPC_LCD_ONE) begin
        op = acc_load_pkg::OP_LCD_ONE;
      end else if ((INSTR & acc_load_pkg::OPC_MEM_MASK) == acc_load_pkg::OPC_MEM_LOAD) begin
        op = acc_load_pkg::OP_MEM_LOAD;
      end
    end
  end

  // ==========================================================================
  // Execute
  // ==========================================================================

  logic [3:0] acc_q;
  logic [3:0] acc_d;
  logic [3:0] memfile_q;
  logic [3:0] memfile_d;
  logic       done_q;
  logic       done_d;

  // Computes the next accumulator and memory-file values; a decoded load wins over a core write.
  always_comb begin
    acc_d     = acc_q;
    memfile_d = memfile_q;
    done_d    = 1'h0;
    if (ACC_WR) begin
      acc_d = ACC_WDATA;
    end
    if (MEMFILE_WR) begin
      memfile_d = MEMFILE_WDATA;
    end
    case (op)
      acc_load_pkg::OP_WAKE_ONE: begin
        acc_d  = WAKEUP_CTRL_ONE;
        done_d = 1'h1;
      end
      acc_load_pkg::OP_WAKE_TWO: begin
        acc_d  = WAKEUP_CTRL_TWO;
        done_d = 1'h1;
      end
      acc_load_pkg::OP_LCD_ONE: begin
        acc_d  = LCD_CTRL_ONE;
        done_d = 1'h1;
      end
      acc_load_pkg::OP_MEM_LOAD: begin
        acc_d     = MEM_RDATA;
        memfile_d = memfile_q ^ imm;
        done_d    = 1'h1;
      end
      default: begin
        done_d = 1'h0;
      end
    endcase
  end

  // Registers the execution state; clock enable low freezes everything except a reset, which still loads the reset values.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      acc_q     <= acc_load_pkg::ACC_RST;
      memfile_q <= acc_load_pkg::MEMFILE_RST;
      done_q    <= 1'h0;
    end else if (CE) begin
      acc_q     <= acc_d;
      memfile_q <= memfile_d;
      done_q    <= done_d;
    end
  end

  // Carry and skip are never requested by these loads, so both stay low from reset.
  logic skip_q;
  logic skip_d;
  logic carry_we_q;
  logic carry_we_d;

  // No load asks for the next instruction to be skipped or for a carry update.
  always_comb begin
    skip_d     = 1'h0;
    carry_we_d = 1'h0;
  end

  // Registers the skip and carry requests under the same reset and enable as the rest.
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      skip_q     <= 1'h0;
      carry_we_q <= 1'h0;
    end else if (CE) begin
      skip_q     <= skip_d;
      carry_we_q <= carry_we_d;
    end
  end

  // Every output comes straight from its register.
  assign ACC       = acc_q;
  assign MEMFILE   = memfile_q;
  assign DONE      = done_q;
  assign SKIP_NEXT = skip_q;
  assign CARRY_WE  = carry_we_q;

  // ==========================================================================
  // Checks
  // ==========================================================================

  // Opcode match worked out apart from the decoder, so the checks do not lean on it.
  logic load_opc;

  assign load_opc = INSTR_VALID && (INSTR == acc_load_pkg::OPC_WAKE_ONE || INSTR == acc_load_pkg::OPC_WAKE_TWO
                    || INSTR == acc_load_pkg::OPC_LCD_ONE
                    || (INSTR & acc_load_pkg::OPC_MEM_MASK) == acc_load_pkg::OPC_MEM_LOAD);

  // A wakeup-control-one read taken at this edge; a reset edge takes nothing.
  sequence wake_one_issued;
    !SYS_RST && CE && INSTR_VALID && INSTR == acc_load_pkg::OPC_WAKE_ONE;
  endsequence

  // A memory load taken at this edge; a reset edge takes nothing.
  sequence mem_load_issued;
    !SYS_RST && CE && INSTR_VALID && (INSTR & acc_load_pkg::OPC_MEM_MASK) == acc_load_pkg::OPC_MEM_LOAD;
  endsequence

  // An enabled edge out of reset that takes none of the handled loads.
  sequence no_load_issued;
    !SYS_RST && CE && !load_opc;
  endsequence

  // Wakeup control one lands in the accumulator one edge after the read is taken.
  wake_one_load_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    wake_one_issued |=> ACC == $past(WAKEUP_CTRL_ONE) && DONE)
    else $error("Wakeup control one was not loaded into the accumulator.");

  // Wakeup control two lands in the accumulator one edge after the read is taken.
  wake_two_load_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !SYS_RST && CE && INSTR_VALID && INSTR == acc_load_pkg::OPC_WAKE_TWO |=> ACC == $past(WAKEUP_CTRL_TWO) && DONE)
    else $error("Wakeup control two was not loaded into the accumulator.");

  // LCD control one lands in the accumulator one edge after the read is taken.
  lcd_one_load_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !SYS_RST && CE && INSTR_VALID && INSTR == acc_load_pkg::OPC_LCD_ONE |=> ACC == $past(LCD_CTRL_ONE) && DONE)
    else $error("LCD control one was not loaded into the accumulator.");

  // The memory nibble lands in the accumulator one edge after the load is taken.
  mem_acc_load_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    mem_load_issued |=> ACC == $past(MEM_RDATA) && DONE)
    else $error("Memory nibble was not loaded into the accumulator.");

  // The memory-file register takes its XOR with the immediate, whatever the core writes.
  memfile_xor_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    mem_load_issued |=> MEMFILE == ($past(MEMFILE) ^ $past(INSTR[3:0])))
    else $error("Memory-file register was not XORed with the immediate.");

  // Without a memory load or a core write the memory-file register holds.
  memfile_kept_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !SYS_RST && CE && !MEMFILE_WR
    && !(INSTR_VALID && (INSTR & acc_load_pkg::OPC_MEM_MASK) == acc_load_pkg::OPC_MEM_LOAD)
    |=> $stable(MEMFILE))
    else $error("Memory-file register changed without a memory load.");

  // Other loads leave a core write of the memory-file register in force.
  memfile_write_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !SYS_RST && CE && MEMFILE_WR
    && !(INSTR_VALID && (INSTR & acc_load_pkg::OPC_MEM_MASK) == acc_load_pkg::OPC_MEM_LOAD)
    |=> MEMFILE == $past(MEMFILE_WDATA))
    else $error("Memory-file register missed a core write.");

  // A completed load never asks for a skip or a carry update.
  no_skip_carry_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    DONE |-> !SKIP_NEXT && !CARRY_WE)
    else $error("A load instruction requested skip or carry update.");

  // Completion is flagged only after an edge that took a load.
  done_idle_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    no_load_issued |=> !DONE)
    else $error("Completion was flagged without a load instruction.");

  // Without a load or a core write the accumulator holds.
  acc_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !SYS_RST && CE && !load_opc && !ACC_WR |=> $stable(ACC))
    else $error("Accumulator changed without a load or a core write.");

  // Without a load a core write reaches the accumulator.
  acc_write_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !SYS_RST && CE && !load_opc && ACC_WR |=> ACC == $past(ACC_WDATA))
    else $error("Accumulator missed a core write.");

  // Clock enable low freezes the accumulator, memory-file and done registers; a reset edge is left out as it overrides the enable.
  freeze_on_ce_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
    !SYS_RST && !CE |=> $stable(ACC) && $stable(MEMFILE) && $stable(DONE))
    else $error("State changed while clock enable was low.");

endmodule : acc_load_instructions

// [tb/tb.sv]
// Self-checking random bench for the accumulator load instruction block.
`timescale 1ns/1ns
module tb;
  logic       clk = 1'h0, rst = 1'h1, ce = 1'h0, vld = 1'h0, awr = 1'h0, mwr = 1'h0;
  logic [9:0] instr = 10'h000;
  logic [3:0] w1 = 4'h0, w2 = 4'h0, lcd = 4'h0, mem = 4'h0, awd = 4'h0, mwd = 4'h0;
  logic [3:0] acc, mf, e_acc, e_mf;
  logic       done, skip, cwe, e_done, ld, mload;
  int         mismatches = 0, cmp_count = 0, cyc = 0;
  logic [31:0] r;

  acc_load_instructions u_dut (.CORE_CLK(clk), .SYS_RST(rst), .CE(ce), .INSTR_VALID(vld), .INSTR(instr),
    .WAKEUP_CTRL_ONE(w1), .WAKEUP_CTRL_TWO(w2), .LCD_CTRL_ONE(lcd), .MEM_RDATA(mem), .ACC_WR(awr),
    .ACC_WDATA(awd), .MEMFILE_WR(mwr), .MEMFILE_WDATA(mwd), .ACC(acc), .MEMFILE(mf), .DONE(done),
    .SKIP_NEXT(skip), .CARRY_WE(cwe));

  // ==========================================================
  // Checking and closing
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Makes the 40 ns clock.
  initial forever #20 clk = ~clk;

  // ==========================================================
  // Reference model
  // Steps the expected state at each edge from the inputs the design samples.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    mload = vld && ((instr & acc_load_pkg::OPC_MEM_MASK) === acc_load_pkg::OPC_MEM_LOAD);
    ld = mload || (vld && (instr === acc_load_pkg::OPC_WAKE_ONE || instr === acc_load_pkg::OPC_WAKE_TWO
         || instr === acc_load_pkg::OPC_LCD_ONE));
    if (rst) begin
      e_acc = acc_load_pkg::ACC_RST;
      e_mf = acc_load_pkg::MEMFILE_RST;
      e_done = 1'h0;
    end else if (ce) begin
      e_done = ld;
      if (awr) e_acc = awd;
      if (mwr && !mload) e_mf = mwd;
      if (vld && instr === acc_load_pkg::OPC_WAKE_ONE) e_acc = w1;
      if (vld && instr === acc_load_pkg::OPC_WAKE_TWO) e_acc = w2;
      if (vld && instr === acc_load_pkg::OPC_LCD_ONE) e_acc = lcd;
      if (mload) e_acc = mem;
      if (mload) e_mf = e_mf ^ instr[3:0];
    end
  end

  // Compares all outputs mid-cycle, once settled, and cuts a hang short.
  always @(negedge clk) begin
    if (cyc > 0) begin
      chk("acc", acc, e_acc);
      chk("memfile", mf, e_mf);
      chk("done", {3'h0, done}, {3'h0, e_done});
      chk("skip", {3'h0, skip}, 4'h0);
      chk("carry_we", {3'h0, cwe}, 4'h0);
    end
    if (cyc >= 3000) begin
      mismatches++;
      end_sim;
    end
  end

  // ==========================================================
  // Stimulus
  // Random back-to-back instructions biased to the load opcodes, with stalls and resets.
  initial begin
    r = $urandom(95196);
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    ce <= 1'h1;
    repeat (2000) begin
      @(posedge clk);
      r = $urandom;
      case (r[2:0])
        3'h0: instr <= acc_load_pkg::OPC_WAKE_ONE;
        3'h1: instr <= acc_load_pkg::OPC_WAKE_TWO;
        3'h2: instr <= acc_load_pkg::OPC_LCD_ONE;
        3'h3, 3'h4: instr <= acc_load_pkg::OPC_MEM_LOAD | {6'h00, r[7:4]};
        default: instr <= r[17:8];
      endcase
      vld <= r[20:18] != 3'h0;
      ce <= r[23:21] != 3'h0;
      rst <= r[29:24] == 6'h00;
      awr <= r[30];
      mwr <= r[31];
      r = $urandom;
      {w1, w2, lcd, mem, awd, mwd} <= r[23:0];
    end
    @(negedge clk);
    end_sim;
  end
endmodule : tb
